// ===== src/tpo_pkg.sv
// constants, types and helpers for the timing pattern output block
package tpo_pkg;

	// ----------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------
	localparam logic [19:0] TPO_IDX_PORT_A_DIR = 20'hEE009;
	localparam logic [19:0] TPO_IDX_PORT_B_DIR = 20'hEE00A;
	localparam logic [19:0] TPO_IDX_MODE = 20'hFFFA0;
	localparam logic [19:0] TPO_IDX_TRIG_SEL = 20'hFFFA1;
	localparam logic [19:0] TPO_IDX_UPPER_EN = 20'hFFFA2;
	localparam logic [19:0] TPO_IDX_LOWER_EN = 20'hFFFA3;
	localparam logic [19:0] TPO_IDX_UPPER_ND = 20'hFFFA4;
	localparam logic [19:0] TPO_IDX_LOWER_ND = 20'hFFFA5;
	localparam logic [19:0] TPO_IDX_UPPER_ND_ALT = 20'hFFFA6;
	localparam logic [19:0] TPO_IDX_LOWER_ND_ALT = 20'hFFFA7;
	localparam logic [19:0] TPO_IDX_PORT_A_DATA = 20'hFFFD9;
	localparam logic [19:0] TPO_IDX_PORT_B_DATA = 20'hFFFDA;

	// ----------------------------------------
	// address slice holding the index
	// ----------------------------------------
	localparam int TPO_IDX_LSB = 2;
	localparam int TPO_IDX_MSB = 21;

	// ----------------------------------------
	// reset values and fixed patterns
	// ----------------------------------------
	localparam logic [7:0] TPO_RESET_ZERO = 8'h00;
	localparam logic [7:0] TPO_RESET_MODE = 8'hF0;
	localparam logic [7:0] TPO_RESET_TRIG_SEL = 8'hFF;
	localparam logic [7:0] TPO_ALL_ONES = 8'hFF;
	localparam logic [3:0] TPO_NIBBLE_ONES = 4'hF;
	localparam logic [3:0] TPO_NIBBLE_ZERO = 4'h0;
	localparam logic [23:0] TPO_RDATA_PAD = 24'h000000;

	// ----------------------------------------
	// group layout and trigger select fields
	// ----------------------------------------
	localparam int TPO_GROUPS = 4;
	localparam int TPO_GROUP_W = 4;
	localparam int TPO_SEL_W = 2;
	localparam logic [1:0] TPO_SEL_CH2_ALIAS = 2'h3;
	localparam logic [1:0] TPO_SEL_CH2 = 2'h2;
	localparam int TPO_CHANNELS = 3;

	// ----------------------------------------
	// bus signalling
	// ----------------------------------------
	localparam int TPO_HTRANS_ACTIVE_BIT = 1;
	localparam logic TPO_HRESP_OKAY = 1'b0;

	typedef enum {
		TPO_BUS_IDLE,
		TPO_BUS_WRITE,
		TPO_BUS_READ_WAIT
	} tpo_bus_state_t;

	// both high select codes mean the same timer channel
	function automatic logic [1:0] tpo_channel(input logic [1:0] sel);
		tpo_channel = (sel == TPO_SEL_CH2_ALIAS) ? TPO_SEL_CH2 : sel;
	endfunction

	// protected bits keep their old value, the rest take the write
	function automatic logic [7:0] tpo_merge(
		input logic [7:0] old_value,
		input logic [7:0] write_value,
		input logic [7:0] protect
	);
		tpo_merge = (old_value & protect) | (write_value & ~protect);
	endfunction

endpackage

// ===== src/tpo_group_trigger.sv
// trigger source selection for one output group
`timescale 1ns/10ps
module tpo_group_trigger import tpo_pkg::*; (
	input wire logic [TPO_SEL_W-1:0] i_select,
	input wire logic [TPO_CHANNELS-1:0] i_compare_match,
	output logic o_fire
);

	always_comb begin
		case (tpo_channel(i_select))
			2'h0: o_fire = i_compare_match[0];
			2'h1: o_fire = i_compare_match[1];
			default: o_fire = i_compare_match[2];
		endcase
	end

endmodule

// ===== src/tpo_timing_pattern_output.sv
// timing pattern output unit with its ahb-lite register slave
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps

// Overview of operation
// - sixteen pattern outputs, four groups of four, group 0 is bits 3-0.
// - port A and B direction registers are 8-bit, write-only, reset zero.
// - port A data holds groups 0-1, port B groups 2-3, both reset zero.
// - port A data bits enabled by lower next enable ignore software writes.
// - port B data bits enabled by upper next enable ignore software writes.
// - selected compare match copies lower next data into port A data bits.
// - next data cleared by reset and hardware standby, kept in software standby.
// - shared trigger: lower next data whole at FFFA5, FFFA7 reads ones.
// - split trigger: group 1 nibble at FFFA5, group 0 nibble at FFFA7.
// - upper next data at FFFA4 shared; split puts group 2 at FFFA6.
// - reset loads mode F0, trigger select FF, both enables zero; all read/write.
// - register decode uses byte address bits 21-2, the 20-bit register index.
// - disabled next data bits are never copied; their outputs hold.
// - select 00 picks channel 0, 01 channel 1, 10 and 11 channel 2.
module tpo_timing_pattern_output import tpo_pkg::*; (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_hw_standby,
	input wire logic [TPO_CHANNELS-1:0] i_compare_match,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	output logic [15:0] o_pattern_output_pin,
	output logic [7:0] o_port_a_direction,
	output logic [7:0] o_port_b_direction
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] pattern_output_mode;
	logic [7:0] pattern_trigger_select;
	logic [7:0] upper_next_enable;
	logic [7:0] lower_next_enable;
	logic [7:0] upper_next_data;
	logic [7:0] lower_next_data;
	logic [7:0] port_a_output_data;
	logic [7:0] port_b_output_data;

	// ----------------------------------------
	// bus state
	// ----------------------------------------
	tpo_bus_state_t bus_state;
	logic [19:0] bus_index;
	logic accept;
	logic write_strobe;
	logic [7:0] write_byte;
	logic [7:0] read_byte;

	// ----------------------------------------
	// trigger state
	// ----------------------------------------
	logic [TPO_GROUPS-1:0] group_fire;
	logic lower_shared;
	logic upper_shared;
	logic [7:0] lower_load;
	logic [7:0] upper_load;
	logic [7:0] port_a_written;
	logic [7:0] port_b_written;
	logic [7:0] next_port_a;
	logic [7:0] next_port_b;

	// hsize is accepted but only the low byte lane carries register data
	assign accept = i_hsel & i_htrans[TPO_HTRANS_ACTIVE_BIT] & i_hready;
	assign write_strobe = (bus_state == TPO_BUS_WRITE);
	assign write_byte = i_hwdata[7:0];

	// ----------------------------------------
	// register write decode
	// ----------------------------------------
	// one enable per register keeps the address compare out of every process
	logic write_mode;
	logic write_trig_sel;
	logic write_upper_en;
	logic write_lower_en;
	logic write_dir_a;
	logic write_dir_b;
	logic write_upper_nd;
	logic write_lower_nd;
	logic write_upper_nd_alt;
	logic write_lower_nd_alt;
	logic write_port_a;
	logic write_port_b;

	assign write_mode = write_strobe && (bus_index == TPO_IDX_MODE);
	assign write_trig_sel = write_strobe && (bus_index == TPO_IDX_TRIG_SEL);
	assign write_upper_en = write_strobe && (bus_index == TPO_IDX_UPPER_EN);
	assign write_lower_en = write_strobe && (bus_index == TPO_IDX_LOWER_EN);
	assign write_dir_a = write_strobe && (bus_index == TPO_IDX_PORT_A_DIR);
	assign write_dir_b = write_strobe && (bus_index == TPO_IDX_PORT_B_DIR);
	assign write_upper_nd = write_strobe && (bus_index == TPO_IDX_UPPER_ND);
	assign write_lower_nd = write_strobe && (bus_index == TPO_IDX_LOWER_ND);
	assign write_upper_nd_alt = write_strobe && (bus_index == TPO_IDX_UPPER_ND_ALT);
	assign write_lower_nd_alt = write_strobe && (bus_index == TPO_IDX_LOWER_ND_ALT);
	assign write_port_a = write_strobe && (bus_index == TPO_IDX_PORT_A_DATA);
	assign write_port_b = write_strobe && (bus_index == TPO_IDX_PORT_B_DATA);

	// ----------------------------------------
	// ahb-lite phase tracking
	// ----------------------------------------
	// reads take one wait state so a write finishing just before is visible
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			bus_state <= TPO_BUS_IDLE;
		end else begin
			case (bus_state)
				TPO_BUS_IDLE, TPO_BUS_WRITE: begin
					if (accept && i_hwrite) begin
						bus_state <= TPO_BUS_WRITE;
					end else if (accept) begin
						bus_state <= TPO_BUS_READ_WAIT;
					end else begin
						bus_state <= TPO_BUS_IDLE;
					end
				end
				TPO_BUS_READ_WAIT: begin
					bus_state <= TPO_BUS_IDLE;
				end
				default: begin
					bus_state <= TPO_BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			bus_index <= '0;
		end else if (accept) begin
			bus_index <= i_haddr[TPO_IDX_MSB:TPO_IDX_LSB];
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_hreadyout <= 1'b1;
		end else if (bus_state == TPO_BUS_READ_WAIT) begin
			o_hreadyout <= 1'b1;
		end else if (accept && !i_hwrite) begin
			o_hreadyout <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_hresp <= TPO_HRESP_OKAY;
		end else begin
			o_hresp <= TPO_HRESP_OKAY;
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_hrdata <= '0;
		end else if (bus_state == TPO_BUS_READ_WAIT) begin
			o_hrdata <= {TPO_RDATA_PAD, read_byte};
		end
	end

	// ----------------------------------------
	// read multiplexer
	// ----------------------------------------
	always_comb begin
		case (bus_index)
			TPO_IDX_MODE: read_byte = pattern_output_mode;
			TPO_IDX_TRIG_SEL: read_byte = pattern_trigger_select;
			TPO_IDX_UPPER_EN: read_byte = upper_next_enable;
			TPO_IDX_LOWER_EN: read_byte = lower_next_enable;
			TPO_IDX_LOWER_ND: begin
				read_byte = lower_shared ? lower_next_data
					: {lower_next_data[7:4], TPO_NIBBLE_ONES};
			end
			TPO_IDX_LOWER_ND_ALT: begin
				read_byte = lower_shared ? TPO_ALL_ONES
					: {TPO_NIBBLE_ONES, lower_next_data[3:0]};
			end
			TPO_IDX_UPPER_ND: begin
				read_byte = upper_shared ? upper_next_data
					: {upper_next_data[7:4], TPO_NIBBLE_ONES};
			end
			TPO_IDX_UPPER_ND_ALT: begin
				read_byte = upper_shared ? TPO_ALL_ONES
					: {TPO_NIBBLE_ONES, upper_next_data[3:0]};
			end
			TPO_IDX_PORT_A_DATA: read_byte = port_a_output_data;
			TPO_IDX_PORT_B_DATA: read_byte = port_b_output_data;
			// direction registers are write-only and read as zero
			default: read_byte = TPO_RESET_ZERO;
		endcase
	end

	// ----------------------------------------
	// trigger selection per group
	// ----------------------------------------
	for (genvar g = 0; g < TPO_GROUPS; g++) begin : gen_group
		tpo_group_trigger u_trigger (
			.i_select(pattern_trigger_select[g*TPO_SEL_W +: TPO_SEL_W]),
			.i_compare_match(i_compare_match),
			.o_fire(group_fire[g])
		);
	end

	// groups compare by channel, so 10 and 11 count as the same trigger
	assign lower_shared = tpo_channel(pattern_trigger_select[1:0])
		== tpo_channel(pattern_trigger_select[3:2]);
	assign upper_shared = tpo_channel(pattern_trigger_select[5:4])
		== tpo_channel(pattern_trigger_select[7:6]);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			pattern_output_mode <= TPO_RESET_MODE;
		end else if (i_hw_standby) begin
			pattern_output_mode <= TPO_RESET_MODE;
		end else if (write_mode) begin
			pattern_output_mode <= write_byte;
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			pattern_trigger_select <= TPO_RESET_TRIG_SEL;
		end else if (i_hw_standby) begin
			pattern_trigger_select <= TPO_RESET_TRIG_SEL;
		end else if (write_trig_sel) begin
			pattern_trigger_select <= write_byte;
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			upper_next_enable <= TPO_RESET_ZERO;
			lower_next_enable <= TPO_RESET_ZERO;
		end else if (i_hw_standby) begin
			upper_next_enable <= TPO_RESET_ZERO;
			lower_next_enable <= TPO_RESET_ZERO;
		end else if (write_upper_en) begin
			upper_next_enable <= write_byte;
		end else if (write_lower_en) begin
			lower_next_enable <= write_byte;
		end
	end

	// direction registers stay across hardware standby; no clear is specified
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_port_a_direction <= TPO_RESET_ZERO;
			o_port_b_direction <= TPO_RESET_ZERO;
		end else if (write_dir_a) begin
			o_port_a_direction <= write_byte;
		end else if (write_dir_b) begin
			o_port_b_direction <= write_byte;
		end
	end

	// ----------------------------------------
	// next data registers
	// ----------------------------------------
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			lower_next_data <= TPO_RESET_ZERO;
		end else if (i_hw_standby) begin
			lower_next_data <= TPO_RESET_ZERO;
		end else if (write_lower_nd) begin
			if (lower_shared) begin
				lower_next_data <= write_byte;
			end else begin
				lower_next_data[7:4] <= write_byte[7:4];
			end
		end else if (write_lower_nd_alt) begin
			if (!lower_shared) begin
				lower_next_data[3:0] <= write_byte[3:0];
			end
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			upper_next_data <= TPO_RESET_ZERO;
		end else if (i_hw_standby) begin
			upper_next_data <= TPO_RESET_ZERO;
		end else if (write_upper_nd) begin
			if (upper_shared) begin
				upper_next_data <= write_byte;
			end else begin
				upper_next_data[7:4] <= write_byte[7:4];
			end
		end else if (write_upper_nd_alt) begin
			if (!upper_shared) begin
				upper_next_data[3:0] <= write_byte[3:0];
			end
		end
	end

	// ----------------------------------------
	// port data update
	// ----------------------------------------
	// a whole group loads at once; only enabled bits take the next data
	assign lower_load = {{TPO_GROUP_W{group_fire[1]}}, {TPO_GROUP_W{group_fire[0]}}}
		& lower_next_enable;
	assign upper_load = {{TPO_GROUP_W{group_fire[3]}}, {TPO_GROUP_W{group_fire[2]}}}
		& upper_next_enable;

	always_comb begin
		port_a_written = port_a_output_data;
		if (write_port_a) begin
			port_a_written = tpo_merge(port_a_output_data, write_byte,
				lower_next_enable);
		end
		next_port_a = (port_a_written & ~lower_load)
			| (lower_next_data & lower_load);
	end

	always_comb begin
		port_b_written = port_b_output_data;
		if (write_port_b) begin
			port_b_written = tpo_merge(port_b_output_data, write_byte,
				upper_next_enable);
		end
		next_port_b = (port_b_written & ~upper_load)
			| (upper_next_data & upper_load);
	end

	// a next-data write in a trigger cycle is too late: the old value moves
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			port_a_output_data <= TPO_RESET_ZERO;
			port_b_output_data <= TPO_RESET_ZERO;
		end else if (i_hw_standby) begin
			port_a_output_data <= TPO_RESET_ZERO;
			port_b_output_data <= TPO_RESET_ZERO;
		end else begin
			port_a_output_data <= next_port_a;
			port_b_output_data <= next_port_b;
		end
	end

	// ----------------------------------------
	// pattern pins
	// ----------------------------------------
	assign o_pattern_output_pin = {port_b_output_data, port_a_output_data};

endmodule

// ===== verif/tpo_timer_model.sv
// behavioural timer channels that raise compare match pulses on request
`timescale 1ns/10ps
module tpo_timer_model (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [2:0] i_request,
	input wire logic [3:0] i_delay,
	output logic [2:0] o_compare_match
);
	logic [2:0] pend;
	logic [3:0] cnt;

	// ----------------------------------------
	// delayed one-cycle match pulses
	// ----------------------------------------
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			pend <= 3'h0;
			cnt <= 4'h0;
			o_compare_match <= 3'h0;
		end else begin
			o_compare_match <= 3'h0;
			if (|i_request) begin
				pend <= i_request;
				cnt <= i_delay;
			end else if (|pend) begin
				// several channels may match together, as real timers can
				if (cnt == 4'h0) begin
					o_compare_match <= pend;
					pend <= 3'h0;
				end else begin
					cnt <= cnt - 4'h1;
				end
			end
		end
	end
endmodule

// ===== verif/tpo_timing_pattern_output_chk.sv
// port-level assertions for the timing pattern output block
`timescale 1ns/10ps
module tpo_timing_pattern_output_chk import tpo_pkg::*; (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_hw_standby,
	input wire logic [2:0] i_compare_match,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic [31:0] o_hrdata,
	input wire logic [15:0] o_pattern_output_pin,
	input wire logic [7:0] o_port_a_direction,
	input wire logic [7:0] o_port_b_direction
);
	logic taken;
	logic wr_q;
	logic [19:0] idx_q;

	assign taken = i_hsel & i_htrans[1] & i_hready;

	// write data phase tracker, the register lands at its closing edge
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			wr_q <= 1'b0;
			idx_q <= 20'h00000;
		end else begin
			wr_q <= taken & i_hwrite;
			idx_q <= i_haddr[TPO_IDX_MSB:TPO_IDX_LSB];
		end
	end

	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);

	// ----------------------------------------
	// sequences and properties
	// ----------------------------------------
	sequence s_read_taken;
		taken && !i_hwrite;
	endsequence
	sequence s_read_answer;
		!o_hreadyout ##1 o_hreadyout;
	endsequence

	property p_okay;
		o_hresp == TPO_HRESP_OKAY;
	endproperty
	property p_read_wait;
		s_read_taken |=> s_read_answer;
	endproperty
	property p_rdata_pad;
		s_read_taken |-> ##2 o_hrdata[31:8] == TPO_RDATA_PAD;
	endproperty
	property p_dir_read_zero;
		s_read_taken ##0 (i_haddr[21:2] == TPO_IDX_PORT_A_DIR) |-> ##2
			o_hrdata == {TPO_RDATA_PAD, TPO_RESET_ZERO};
	endproperty
	property p_dir_a_write;
		wr_q && idx_q == TPO_IDX_PORT_A_DIR |=> o_port_a_direction == $past(i_hwdata[7:0]);
	endproperty
	property p_dir_b_cause;
		$changed(o_port_b_direction) |-> $past(wr_q && idx_q == TPO_IDX_PORT_B_DIR);
	endproperty
	property p_pins_cause;
		$changed(o_pattern_output_pin) |-> $past(|i_compare_match || wr_q || i_hw_standby);
	endproperty
	property p_standby_clear;
		i_hw_standby |=> o_pattern_output_pin == {TPO_RESET_ZERO, TPO_RESET_ZERO};
	endproperty

	a_okay: assert property (p_okay) else $error("response not okay");
	a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
	a_rdata_pad: assert property (p_rdata_pad) else $error("read pad not zero");
	a_dir_read_zero: assert property (p_dir_read_zero) else $error("dir read");
	a_dir_a_write: assert property (p_dir_a_write) else $error("dir a write lost");
	a_dir_b_cause: assert property (p_dir_b_cause) else $error("dir b changed");
	a_pins_cause: assert property (p_pins_cause) else $error("pins changed");
	a_standby_clear: assert property (p_standby_clear) else $error("standby");
endmodule

bind tpo_timing_pattern_output tpo_timing_pattern_output_chk u_chk (
	.i_clock(i_clock), .i_reset(i_reset), .i_hw_standby(i_hw_standby),
	.i_compare_match(i_compare_match), .i_hsel(i_hsel), .i_haddr(i_haddr),
	.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
	.o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
	.o_pattern_output_pin(o_pattern_output_pin), .o_port_a_direction(o_port_a_direction),
	.o_port_b_direction(o_port_b_direction)
);

// ===== verif/tb_timing_pattern_output.sv
// self-checking bench for the timing pattern output block
`timescale 1ns/10ps
module tb_timing_pattern_output import tpo_pkg::*;;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic standby = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic [15:0] pins;
	logic [7:0] dir_a;
	logic [7:0] dir_b;
	logic [2:0] req = 3'h0;
	logic [3:0] dly = 4'h0;
	logic [2:0] cm;
	logic [9:0] ahi = 10'h000;
	int miscompares = 0;
	int n_compared = 0;
	logic [19:0] ri [11] = '{TPO_IDX_MODE, TPO_IDX_TRIG_SEL, TPO_IDX_UPPER_EN,
		TPO_IDX_LOWER_EN, TPO_IDX_UPPER_ND, TPO_IDX_LOWER_ND, TPO_IDX_UPPER_ND_ALT,
		TPO_IDX_LOWER_ND_ALT, TPO_IDX_PORT_A_DATA, TPO_IDX_PORT_B_DATA, TPO_IDX_PORT_A_DIR};
	logic [7:0] rv [11] = '{8'hF0, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
		8'h00, 8'h00, 8'h00};

	tpo_timing_pattern_output dut (.i_clock(clock), .i_reset(reset), .i_hw_standby(standby),
		.i_compare_match(cm), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
		.o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
		.o_pattern_output_pin(pins), .o_port_a_direction(dir_a), .o_port_b_direction(dir_b));
	tpo_timer_model tmr (.i_clock(clock), .i_reset(reset), .i_request(req), .i_delay(dly),
		.o_compare_match(cm));

	initial begin
		forever #4 clock = ~clock;
	end

	// ----------------------------------------
	// compare, bus and trigger tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	// sampled right after the edge, before the slave's own updates land
	task automatic wait_rdy();
		do @(posedge clock); while (hready !== 1'b1);
	endtask
	task automatic wr(input logic [19:0] idx, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {ahi, idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		wait_rdy();
	endtask
	task automatic rd(input logic [19:0] idx, input logic [7:0] exp);
		hsel <= 1'b1;
		haddr <= {ahi, idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		wait_rdy();
		htrans <= 2'h0;
		wait_rdy();
		chk($sformatf("register %h", idx), {24'h000000, exp}, hrdata);
	endtask
	task automatic trig(input logic [2:0] m, input logic [3:0] d, input logic [15:0] exp);
		int n;
		req <= m;
		dly <= d;
		@(posedge clock);
		req <= 3'h0;
		n = 0;
		while (cm !== m && n < 40) begin
			@(posedge clock);
			n++;
		end
		// pins load at the match edge; look at the next edge, once they stand
		@(posedge clock);
		chk("pins", {16'h0000, exp}, {16'h0000, pins});
	endtask
	task automatic check_table();
		for (int k = 0; k < 11; k++) rd(ri[k], rv[k]);
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		print_verdict();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		check_table();
		wr(TPO_IDX_PORT_A_DIR, 8'hFF);
		// upper address bits set, the decode must ignore them
		ahi = 10'h3C1;
		wr(TPO_IDX_PORT_B_DIR, 8'hA5);
		ahi = 10'h000;
		@(posedge clock);
		chk("dir a", 32'hFF, {24'h0, dir_a});
		chk("dir b", 32'hA5, {24'h0, dir_b});
		wr(TPO_IDX_MODE, 8'h3C);
		rd(TPO_IDX_MODE, 8'h3C);
		wr(TPO_IDX_TRIG_SEL, 8'h00);
		wr(TPO_IDX_PORT_B_DATA, 8'h30);
		wr(TPO_IDX_UPPER_EN, 8'h0F);
		wr(TPO_IDX_PORT_B_DATA, 8'hFF);
		rd(TPO_IDX_PORT_B_DATA, 8'hF0);
		wr(TPO_IDX_LOWER_EN, 8'hFF);
		wr(TPO_IDX_PORT_A_DATA, 8'h77);
		rd(TPO_IDX_PORT_A_DATA, 8'h00);
		wr(TPO_IDX_LOWER_ND, 8'h5A);
		wr(TPO_IDX_UPPER_ND, 8'hC3);
		rd(TPO_IDX_LOWER_ND_ALT, 8'hFF);
		wr(TPO_IDX_LOWER_ND_ALT, 8'h00);
		rd(TPO_IDX_LOWER_ND, 8'h5A);
		trig(3'h2, 4'h0, 16'hF000);
		trig(3'h1, 4'h3, 16'hF35A);
		rd(TPO_IDX_PORT_A_DATA, 8'h5A);
		// groups 0 and 1 split, groups 2 and 3 share channel 2 via codes 10 and 11
		wr(TPO_IDX_TRIG_SEL, 8'hE4);
		rd(TPO_IDX_LOWER_ND, 8'h5F);
		rd(TPO_IDX_LOWER_ND_ALT, 8'hFA);
		rd(TPO_IDX_UPPER_ND, 8'hC3);
		wr(TPO_IDX_LOWER_ND, 8'h9F);
		wr(TPO_IDX_LOWER_ND_ALT, 8'hF6);
		rd(TPO_IDX_LOWER_ND, 8'h9F);
		wr(TPO_IDX_UPPER_EN, 8'hFF);
		trig(3'h2, 4'h0, 16'hF39A);
		trig(3'h4, 4'h1, 16'hC39A);
		trig(3'h1, 4'h0, 16'hC396);
		wr(TPO_IDX_TRIG_SEL, 8'h64);
		wr(TPO_IDX_UPPER_ND_ALT, 8'h01);
		rd(TPO_IDX_UPPER_ND, 8'hCF);
		rd(TPO_IDX_UPPER_ND_ALT, 8'hF1);
		trig(3'h6, 4'h2, 16'hC196);
		standby <= 1'b1;
		@(posedge clock);
		standby <= 1'b0;
		@(posedge clock);
		chk("pins", 32'h0, {16'h0, pins});
		check_table();
		chk("dir a", 32'hFF, {24'h0, dir_a});
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		chk("dir a", 32'h0, {24'h0, dir_a});
		rd(TPO_IDX_TRIG_SEL, 8'hFF);
		print_verdict();
	end
endmodule
